//--- src/apb_cfg_regs.sv
// APB slave holding the audio path, split and framing registers plus a status word.
// Assumes the lock level arrives already synchronised to mclk.
`timescale 1ns/100ps
module apb_cfg_regs (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic        lock_level,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [7:0]  path_cfg_reg,
  output logic      [7:0]  split_cfg_reg,
  output logic      [7:0]  framing_cfg_reg
);

  logic        setup;
  logic        wr_take;
  logic        mapped;
  logic [7:0]  rd_value;

  assign setup   = psel & ~penable;
  assign wr_take = psel & penable & pwrite & pready;

  always_comb
  begin
    mapped   = 1'b1;
    rd_value = 8'h00;
    case (paddr)
      audio_tdm_pkg::PATH_CFG_ADDR:    rd_value = path_cfg_reg;
      audio_tdm_pkg::SPLIT_CFG_ADDR:   rd_value = split_cfg_reg;
      audio_tdm_pkg::FRAMING_CFG_ADDR: rd_value = framing_cfg_reg;
      audio_tdm_pkg::STATUS_ADDR:      rd_value[audio_tdm_pkg::STATUS_LOCK_BIT] = lock_level;
      default:                         mapped = 1'b0;
    endcase
  end

  // Zero wait states: ready rises in the access phase of every transfer
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= (setup & ~pwrite) ? {24'h00_0000, rd_value} : 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      path_cfg_reg    <= audio_tdm_pkg::PATH_CFG_RST;
      split_cfg_reg   <= audio_tdm_pkg::SPLIT_CFG_RST;
      framing_cfg_reg <= audio_tdm_pkg::FRAMING_CFG_RST;
    end
    else if (wr_take)
    begin
      case (paddr)
        audio_tdm_pkg::PATH_CFG_ADDR:
          path_cfg_reg <= pwdata[7:0] & audio_tdm_pkg::PATH_CFG_MASK; // see [R2]
        audio_tdm_pkg::SPLIT_CFG_ADDR:
          split_cfg_reg <= pwdata[7:0] & audio_tdm_pkg::SPLIT_CFG_MASK;
        audio_tdm_pkg::FRAMING_CFG_ADDR:
          framing_cfg_reg <= pwdata[7:0] & audio_tdm_pkg::FRAMING_MASK;
        default:
          path_cfg_reg <= path_cfg_reg;
      endcase
    end
  end

endmodule : apb_cfg_regs

//--- src/audio_tdm_conversion_cfg.sv
// Audio lane to TDM serializer and TDM to lane splitter, configured over APB.
// Assumes audio_bclk is the link bit clock, unrelated to mclk; pins are resampled on it.
//
// Behaviour
// [R1] With the serialize enable set, the four lane inputs are merged into one TDM stream on the serial line.
// [R2] Source select 0 disables audio transport and 1 takes audio from the lane pins, resetting to 1.
// [R3] With the split enable set, TDM on the serial input is split onto four lane outputs.
// [R4] Frame sync polarity 0 means active high and 1 means active low like a word select.
// [R5] Each frame carries one active frame sync pulse marking its first sample.
// [R6] Polarity and data delay govern both the TDM output and the accepted TDM input.
// [R7] Delay 0 starts data at the active sync edge and delay 1 starts it one bit clock later.
// [R8] The generated sync is half the frame for 00, one slot for 01 and one bit clock for 1x.
// [R9] Lanes occupy consecutive slots in fixed order lane 0 first, so merge and split are inverse.
`timescale 1ns/100ps
module audio_tdm_conversion_cfg (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        audio_bclk,
  input  wire logic [3:0]  lane_data_in,
  input  wire logic        serial_audio_line_in,
  input  wire logic        frame_sync_in,
  output logic             serial_audio_line_out,
  output logic             frame_sync_out,
  output logic      [3:0]  lane_data_out,
  output logic             lane_sck_out,
  output logic             lane_ws_out
);

  logic [7:0]  path_cfg_reg;
  logic [7:0]  split_cfg_reg;
  logic [7:0]  framing_cfg_reg;
  logic        lock_meta_reg;
  logic        lock_sync_reg;
  logic        b_rst_meta_reg;
  logic        b_rst_n_reg;
  logic [6:0]  cfg_meta_reg;
  logic [6:0]  cfg_sync_reg;
  logic [3:0]  lane_meta_reg;
  logic [3:0]  lane_sync_reg;
  logic        sd_meta_reg;
  logic        sd_sync_reg;
  logic        fs_meta_reg;
  logic        fs_sync_reg;
  logic        fs_prev_reg;
  logic [5:0]  cnt_reg;
  logic [5:0]  cnt_next;
  logic [15:0] lane_in_sh_reg  [4];
  logic [15:0] cap_word_reg    [4];
  logic [15:0] lane_out_sh_reg [4];
  logic [63:0] tx_word;
  logic [63:0] tx_sh_reg;
  logic [63:0] rx_sh_reg;
  logic [63:0] rx_word_reg;
  logic [5:0]  rx_bits_reg;
  logic        rx_run_reg;
  logic        rx_lock_reg;
  logic        split_en;
  logic        tdm_en;
  logic        mode_on;
  logic        pol;
  logic        delay;
  logic [1:0]  width;
  logic        tdm_on;
  logic        lane_tick;
  logic        frame_end;
  logic        tx_load;
  logic        fs_act;
  logic        fs_in_act;
  logic        rx_start;
  logic        rx_take;
  logic        rx_done;
  logic        fs_active_out;
  logic [6:0]  cfg_seen_reg;
  logic [7:0]  cfg_age_reg;
  logic        chk_on;

  apb_cfg_regs u_regs (
    .mclk            (mclk),
    .arst_n          (arst_n),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .lock_level      (lock_sync_reg),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .path_cfg_reg    (path_cfg_reg),
    .split_cfg_reg   (split_cfg_reg),
    .framing_cfg_reg (framing_cfg_reg)
  );

  // Lock status back into the register clock
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lock_meta_reg <= 1'b0;
      lock_sync_reg <= 1'b0;
    end
    else
    begin
      lock_meta_reg <= rx_lock_reg;
      lock_sync_reg <= lock_meta_reg;
    end
  end

  // Reset release synchronised to the bit clock
  always_ff @(posedge audio_bclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      b_rst_meta_reg <= 1'b0;
      b_rst_n_reg    <= 1'b0;
    end
    else
    begin
      b_rst_meta_reg <= 1'b1;
      b_rst_n_reg    <= b_rst_meta_reg;
    end
  end

  // Config is quasi-static; a change mid-frame may glitch that one frame
  always_ff @(posedge audio_bclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_meta_reg <= 7'h00;
      cfg_sync_reg <= 7'h00;
    end
    else
    begin
      cfg_meta_reg <= {split_cfg_reg[audio_tdm_pkg::SPLIT_EN_BIT],
                       path_cfg_reg[audio_tdm_pkg::PATH_TDM_BIT],
                       path_cfg_reg[audio_tdm_pkg::PATH_MODE_BIT],
                       framing_cfg_reg[audio_tdm_pkg::FS_POL_BIT],
                       framing_cfg_reg[audio_tdm_pkg::DELAY_BIT],
                       framing_cfg_reg[audio_tdm_pkg::WIDTH_MSB:0]};
      cfg_sync_reg <= cfg_meta_reg;
    end
  end

  assign split_en  = cfg_sync_reg[6];
  assign tdm_en    = cfg_sync_reg[5];
  assign mode_on   = cfg_sync_reg[4];
  assign pol       = cfg_sync_reg[3];
  assign delay     = cfg_sync_reg[2];
  assign width     = cfg_sync_reg[1:0];
  assign tdm_on    = mode_on & tdm_en;

  // Pin inputs resampled twice
  always_ff @(posedge audio_bclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lane_meta_reg <= 4'h0;
      lane_sync_reg <= 4'h0;
      sd_meta_reg   <= 1'b0;
      sd_sync_reg   <= 1'b0;
      fs_meta_reg   <= 1'b0;
      fs_sync_reg   <= 1'b0;
    end
    else
    begin
      lane_meta_reg <= lane_data_in;
      lane_sync_reg <= lane_meta_reg;
      sd_meta_reg   <= serial_audio_line_in;
      sd_sync_reg   <= sd_meta_reg;
      fs_meta_reg   <= frame_sync_in;
      fs_sync_reg   <= fs_meta_reg;
    end
  end

  assign cnt_next  = cnt_reg + 6'h01;
  assign lane_tick = (cnt_reg[1:0] == audio_tdm_pkg::LANE_TICK);
  assign frame_end = (cnt_reg == audio_tdm_pkg::FRAME_LAST);

  always_ff @(posedge audio_bclk or negedge b_rst_n_reg)
  begin
    if (!b_rst_n_reg)
      cnt_reg <= 6'h00;
    else
      cnt_reg <= cnt_next;
  end

  // Lane clock runs at a quarter of the bit clock, word select at one sixty-fourth (one period per frame)
  always_ff @(posedge audio_bclk or negedge b_rst_n_reg)
  begin
    if (!b_rst_n_reg)
    begin
      lane_sck_out <= 1'b0;
      lane_ws_out  <= 1'b0;
    end
    else
    begin
      lane_sck_out <= cnt_next[1];
      lane_ws_out  <= cnt_next[5];
    end
  end

  // Per-lane capture and replay, one slot per lane per frame
  for (genvar i = 0; i < audio_tdm_pkg::LANES; i++)
  begin : g_lane
    always_ff @(posedge audio_bclk or negedge b_rst_n_reg)
    begin
      if (!b_rst_n_reg)
      begin
        lane_in_sh_reg[i] <= 16'h0000;
        cap_word_reg[i]   <= 16'h0000;
      end
      else if (lane_tick)
      begin
        lane_in_sh_reg[i] <= {lane_in_sh_reg[i][14:0], lane_sync_reg[i]};
        if (frame_end)
          cap_word_reg[i] <= {lane_in_sh_reg[i][14:0], lane_sync_reg[i]};
      end
    end

    assign tx_word[63-16*i -: 16] = cap_word_reg[i]; // see [R9]

    always_ff @(posedge audio_bclk or negedge b_rst_n_reg)
    begin
      if (!b_rst_n_reg)
      begin
        lane_out_sh_reg[i] <= 16'h0000;
        lane_data_out[i]   <= 1'b0;
      end
      else if (!split_en)
      begin
        lane_out_sh_reg[i] <= 16'h0000;
        lane_data_out[i]   <= 1'b0;
      end
      else if (frame_end)
      begin
        lane_out_sh_reg[i] <= {rx_word_reg[62-16*i -: 15], 1'b0}; // see [R3] [R9]
        lane_data_out[i]   <= rx_word_reg[63-16*i];
      end
      else if (lane_tick)
      begin
        lane_out_sh_reg[i] <= {lane_out_sh_reg[i][14:0], 1'b0};
        lane_data_out[i]   <= lane_out_sh_reg[i][15];
      end
    end
  end

  // Delay 1 loads the frame one bit clock after the sync edge
  assign tx_load = delay ? (cnt_reg == 6'h00) : frame_end; // see [R7] [R6]

  always_ff @(posedge audio_bclk or negedge b_rst_n_reg)
  begin
    if (!b_rst_n_reg)
    begin
      tx_sh_reg             <= 64'h0000_0000_0000_0000;
      serial_audio_line_out <= 1'b0;
    end
    else if (!mode_on)
    begin
      tx_sh_reg             <= 64'h0000_0000_0000_0000;
      serial_audio_line_out <= 1'b0; // see [R2]
    end
    else if (!tdm_en)
    begin
      tx_sh_reg             <= 64'h0000_0000_0000_0000;
      serial_audio_line_out <= lane_sync_reg[0];
    end
    else if (tx_load)
    begin
      tx_sh_reg             <= {tx_word[62:0], 1'b0}; // see [R1]
      serial_audio_line_out <= tx_word[63];
    end
    else
    begin
      tx_sh_reg             <= {tx_sh_reg[62:0], 1'b0};
      serial_audio_line_out <= tx_sh_reg[63];
    end
  end

  always_comb
  begin
    case (width)
      audio_tdm_pkg::FS_W_HALF: fs_act = (cnt_next < audio_tdm_pkg::FRAME_HALF); // see [R8]
      audio_tdm_pkg::FS_W_SLOT: fs_act = (cnt_next[5:4] == 2'b00);
      default:                  fs_act = (cnt_next == 6'h00);
    endcase
  end

  // Idle level is the inactive level of the chosen polarity
  always_ff @(posedge audio_bclk or negedge b_rst_n_reg)
  begin
    if (!b_rst_n_reg)
      frame_sync_out <= 1'b0;
    else if (tdm_on)
      frame_sync_out <= fs_act ^ pol; // see [R4] [R5]
    else
      frame_sync_out <= pol;
  end

  // Receive side: an active sync edge starts a 64-bit frame
  assign fs_in_act = fs_sync_reg ^ pol; // see [R4] [R6]
  assign rx_start  = split_en & fs_in_act & ~fs_prev_reg; // see [R5]
  assign rx_take   = split_en & (rx_run_reg | (rx_start & ~delay)); // see [R7]
  // With delay 1 the last bit of a frame shares its cycle with the next sync edge
  assign rx_done   = split_en & rx_run_reg & (rx_bits_reg == audio_tdm_pkg::FRAME_LAST)
                     & ~(rx_start & ~delay);

  always_ff @(posedge audio_bclk or negedge b_rst_n_reg)
  begin
    if (!b_rst_n_reg)
      fs_prev_reg <= 1'b1;
    else
      fs_prev_reg <= fs_in_act;
  end

  always_ff @(posedge audio_bclk or negedge b_rst_n_reg)
  begin
    if (!b_rst_n_reg)
    begin
      rx_run_reg  <= 1'b0;
      rx_bits_reg <= 6'h00;
    end
    else if (!split_en)
    begin
      rx_run_reg  <= 1'b0;
      rx_bits_reg <= 6'h00;
    end
    else if (rx_start)
    begin
      rx_run_reg  <= 1'b1;
      rx_bits_reg <= delay ? 6'h00 : 6'h01;
    end
    else if (rx_run_reg)
    begin
      rx_bits_reg <= rx_bits_reg + 6'h01;
      if (rx_done)
        rx_run_reg <= 1'b0;
    end
  end

  always_ff @(posedge audio_bclk or negedge b_rst_n_reg)
  begin
    if (!b_rst_n_reg)
      rx_sh_reg <= 64'h0000_0000_0000_0000;
    else if (rx_take)
      rx_sh_reg <= {rx_sh_reg[62:0], sd_sync_reg};
  end

  // Lock drops only when splitting is turned off
  always_ff @(posedge audio_bclk or negedge b_rst_n_reg)
  begin
    if (!b_rst_n_reg)
    begin
      rx_word_reg <= 64'h0000_0000_0000_0000;
      rx_lock_reg <= 1'b0;
    end
    else if (!split_en)
      rx_lock_reg <= 1'b0;
    else if (rx_done)
    begin
      rx_word_reg <= {rx_sh_reg[62:0], sd_sync_reg}; // see [R3]
      rx_lock_reg <= 1'b1;
    end
  end

  assign fs_active_out = tdm_on & (frame_sync_out != pol);

  // Checks rest for two frames after a config change, since that frame may glitch
  always_ff @(posedge audio_bclk or negedge b_rst_n_reg)
  begin
    if (!b_rst_n_reg)
    begin
      cfg_seen_reg <= 7'h00;
      cfg_age_reg  <= 8'h00;
    end
    else
    begin
      cfg_seen_reg <= cfg_sync_reg;
      if (cfg_seen_reg != cfg_sync_reg)
        cfg_age_reg <= 8'h00;
      else if (!cfg_age_reg[7])
        cfg_age_reg <= cfg_age_reg + 8'h01;
    end
  end

  assign chk_on = b_rst_n_reg & cfg_age_reg[7] & (cfg_seen_reg == cfg_sync_reg);

  fs_pulse_a: assert property (@(posedge audio_bclk) disable iff (!chk_on) // see [R8]
    (fs_active_out && width[1]) ##1 $stable(cfg_sync_reg) |-> !fs_active_out)
    else $error("One-clock frame sync lasted too long");
  fs_half_a: assert property (@(posedge audio_bclk) disable iff (!chk_on) // see [R8]
    ($rose(fs_active_out) && width == audio_tdm_pkg::FS_W_HALF)
      |-> ##31 fs_active_out ##1 !fs_active_out)
    else $error("Half-frame sync width wrong");
  fs_frame_a: assert property (@(posedge audio_bclk) disable iff (!chk_on) // see [R5]
    ($rose(fs_active_out) && width[1]) |-> ##64 $rose(fs_active_out))
    else $error("Frame sync not once per frame");
  idle_out_a: assert property (@(posedge audio_bclk) disable iff (!chk_on) // see [R2] [R4]
    (!mode_on ##1 !mode_on) |-> (serial_audio_line_out == 1'b0 && frame_sync_out == pol))
    else $error("Disabled path not idle");
  tx_first_bit_a: assert property (@(posedge audio_bclk) disable iff (!chk_on) // see [R1] [R7]
    ($rose(fs_active_out) && !delay) |-> serial_audio_line_out == $past(tx_word[63]))
    else $error("First TDM bit not at sync edge");
  tx_delay_a: assert property (@(posedge audio_bclk) disable iff (!chk_on) // see [R7] [R6]
    ($rose(fs_active_out) && delay) |=> serial_audio_line_out == $past(tx_word[63]))
    else $error("Delayed TDM bit misplaced");
  rx_nodelay_a: assert property (@(posedge audio_bclk) disable iff (!chk_on) // see [R6]
    (rx_start && !delay) ##1 (!rx_start && split_en)[*8] |-> ##55 rx_done)
    else $error("Receive frame not closed after 64 bits");
  rx_delay_a: assert property (@(posedge audio_bclk) disable iff (!chk_on) // see [R7]
    (rx_start && delay) ##1 (!rx_start && split_en)[*8] |-> ##56 rx_done)
    else $error("Delayed receive frame misaligned");
  split_slot_a: assert property (@(posedge audio_bclk) disable iff (!chk_on) // see [R3] [R9]
    (frame_end && split_en) |=> (lane_data_out[0] == $past(rx_word_reg[63])
      && lane_data_out[3] == $past(rx_word_reg[15])))
    else $error("Lane slot order wrong");

  rx_frame_c:   cover property (@(posedge audio_bclk) disable iff (!b_rst_n_reg) rx_done);
  tx_delay_c:   cover property (@(posedge audio_bclk) disable iff (!b_rst_n_reg)
    $rose(fs_active_out) && delay);
  passthru_c:   cover property (@(posedge audio_bclk) disable iff (!b_rst_n_reg)
    mode_on && !tdm_en);

endmodule : audio_tdm_conversion_cfg

//--- src/audio_tdm_pkg.sv
// Constants for the audio TDM conversion block: register map, fields, resets, frame layout.
// Assumes a 32-bit APB with byte addresses; each register sits at four times its index.
package audio_tdm_pkg;

  // Register indices; byte address is index times four
  localparam logic [7:0]  PATH_CFG_IDX    = 8'h54;
  localparam logic [7:0]  SPLIT_CFG_IDX   = 8'h55;
  localparam logic [7:0]  FRAMING_CFG_IDX = 8'h57;
  localparam logic [7:0]  STATUS_IDX      = 8'h58;
  localparam int          ADDR_W          = 12;
  localparam logic [11:0] PATH_CFG_ADDR    = {2'b00, PATH_CFG_IDX, 2'b00};
  localparam logic [11:0] SPLIT_CFG_ADDR   = {2'b00, SPLIT_CFG_IDX, 2'b00};
  localparam logic [11:0] FRAMING_CFG_ADDR = {2'b00, FRAMING_CFG_IDX, 2'b00};
  localparam logic [11:0] STATUS_ADDR      = {2'b00, STATUS_IDX, 2'b00};

  // Field positions
  localparam int PATH_TDM_BIT   = 2;
  localparam int PATH_MODE_BIT  = 1;
  localparam int SPLIT_EN_BIT   = 7;
  localparam int FS_POL_BIT     = 3;
  localparam int DELAY_BIT      = 2;
  localparam int WIDTH_MSB      = 1;
  localparam int STATUS_LOCK_BIT = 0;

  // Reset values and writable masks
  localparam logic [7:0] PATH_CFG_RST    = 8'h02;
  localparam logic [7:0] SPLIT_CFG_RST   = 8'h00;
  localparam logic [7:0] FRAMING_CFG_RST = 8'h02;
  localparam logic [7:0] PATH_CFG_MASK   = 8'h06;
  localparam logic [7:0] SPLIT_CFG_MASK  = 8'h80;
  localparam logic [7:0] FRAMING_MASK    = 8'h0F;

  // Frame sync width codes
  localparam logic [1:0] FS_W_HALF = 2'b00;
  localparam logic [1:0] FS_W_SLOT = 2'b01;

  // Frame layout: four lanes, one 16-bit slot each, 64 bit clocks per frame
  localparam int         LANES      = 4;
  localparam int         SLOT_BITS  = 16;
  localparam int         FRAME_BITS = 64;
  localparam int         CNT_W      = 6;
  localparam logic [5:0] FRAME_LAST = 6'h3F;
  localparam logic [5:0] FRAME_HALF = 6'h20;
  localparam logic [1:0] LANE_TICK  = 2'b11;

endpackage : audio_tdm_pkg

//--- test/audio_far_end.sv
// Far-end model: I2S lane source plus a TDM source that can loop the device's own TDM back.
// Assumes audio_bclk runs free; every output changes just after its rising edge.
`timescale 1ns/100ps
module audio_far_end (
  input  wire logic        audio_bclk,
  input  wire logic [3:0]  lane_level,
  input  wire logic        loop_back,
  input  wire logic        gen_pol,
  input  wire logic        gen_delay,
  input  wire logic [63:0] gen_word,
  input  wire logic        tdm_line_from_dev,
  input  wire logic        fs_from_dev,
  output logic      [3:0]  lane_data_in,
  output logic             serial_audio_line_in,
  output logic             frame_sync_in
);
  logic [5:0] gen_cnt_reg;
  logic [5:0] bit_idx;

  // Delay 1 shifts the whole word one bit clock behind the sync edge
  assign bit_idx = gen_cnt_reg - {5'h00, gen_delay};

  initial
  begin
    gen_cnt_reg = 6'h00;
    lane_data_in = 4'h0;
    serial_audio_line_in = 1'b0;
    frame_sync_in = 1'b0;
  end

  always @(posedge audio_bclk)
  begin
    gen_cnt_reg <= gen_cnt_reg + 6'h01;
    lane_data_in <= lane_level;
    if (loop_back)
    begin
      serial_audio_line_in <= tdm_line_from_dev;
      frame_sync_in <= fs_from_dev;
    end
    else
    begin
      frame_sync_in <= (gen_cnt_reg == 6'h00) ^ gen_pol;
      serial_audio_line_in <= gen_word[6'h3F - bit_idx];
    end
  end
endmodule : audio_far_end

//--- test/audio_tdm_conversion_cfg_tb_top.sv
// Testbench for the audio TDM block: APB registers, TDM generation, TDM splitting.
// Assumes audio_far_end as the far side; bclk is free running and unrelated to mclk.
`timescale 1ns/100ps
module audio_tdm_conversion_cfg_tb_top;
  logic        mclk;
  logic        arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        audio_bclk;
  logic [3:0]  lane_data_in;
  logic        serial_audio_line_in;
  logic        frame_sync_in;
  logic        serial_audio_line_out;
  logic        frame_sync_out;
  logic [3:0]  lane_data_out;
  logic [3:0]  lane_level;
  logic        loop_back;
  logic        gen_pol;
  logic        gen_delay;
  logic [63:0] gen_word;
  logic [63:0] got_d;
  logic [63:0] got_f;
  logic [63:0] got_l;
  logic [63:0] got_k;
  logic [63:0] got_w;
  logic        lane_sck;
  logic        lane_ws;
  int          mismatches;
  int          comparisons;
  int          cycles;

  audio_tdm_conversion_cfg u_dut (
    .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .audio_bclk(audio_bclk), .lane_data_in(lane_data_in),
    .serial_audio_line_in(serial_audio_line_in), .frame_sync_in(frame_sync_in),
    .serial_audio_line_out(serial_audio_line_out), .frame_sync_out(frame_sync_out),
    .lane_data_out(lane_data_out), .lane_sck_out(lane_sck), .lane_ws_out(lane_ws)
  );

  audio_far_end u_far_end (
    .audio_bclk(audio_bclk), .lane_level(lane_level), .loop_back(loop_back),
    .gen_pol(gen_pol), .gen_delay(gen_delay), .gen_word(gen_word),
    .tdm_line_from_dev(serial_audio_line_out), .fs_from_dev(frame_sync_out),
    .lane_data_in(lane_data_in), .serial_audio_line_in(serial_audio_line_in),
    .frame_sync_in(frame_sync_in)
  );

  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;
  initial audio_bclk = 1'b0;
  always #32 audio_bclk = ~audio_bclk;

  task automatic tally_and_finish();
    if (mismatches == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  // Roughly twice the expected run length
  always @(posedge mclk)
  begin
    cycles = cycles + 1;
    if (cycles == 40000)
    begin
      mismatches = mismatches + 1;
      tally_and_finish();
    end
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic apb_xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                          output logic [31:0] rdata, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer

  task automatic apb_write(input logic [11:0] addr, input logic [31:0] wdata);
    logic [31:0] r;
    logic        e;
    apb_xfer(1'b1, addr, wdata, r, e);
  endtask : apb_write

  task automatic apb_read_check(input logic [11:0] addr, input logic [31:0] exp, input logic ee);
    logic [31:0] r;
    logic        e;
    apb_xfer(1'b0, addr, 32'h0000_0000, r, e);
    check({32'h0000_0000, r}, {32'h0000_0000, exp}, "read data");
    check({63'h0, e}, {63'h0, ee}, "slave error");
  endtask : apb_read_check

  // Optionally waits for an active sync edge, then samples one frame at falling bclk edges
  task automatic grab(input logic seek, input logic pol, input logic [3:0] lexp);
    logic prev;
    prev = 1'b1;
    for (int n = 0; n < 200 && seek; n++)
    begin
      @(negedge audio_bclk);
      if (prev === 1'b0 && (frame_sync_out ^ pol) === 1'b1)
        break;
      prev = frame_sync_out ^ pol;
    end
    for (int i = 63; i >= 0; i--)
    begin
      if (!seek || i < 63)
        @(negedge audio_bclk);
      got_d[i] = serial_audio_line_out;
      got_f[i] = frame_sync_out ^ pol;
      got_l[i] = (lane_data_out !== lexp);
      got_k[i] = lane_sck;
      got_w[i] = lane_ws;
    end
  endtask : grab

  function automatic logic [63:0] exp_tdm(input logic [3:0] lanes, input logic delay);
    logic [63:0] v;
    logic [5:0]  j;
    for (int i = 0; i < 64; i++)
    begin
      j = i[5:0] - {5'h00, delay};
      v[63 - i] = lanes[j[5:4]];
    end
    return v;
  endfunction : exp_tdm

  task automatic test_registers();
    apb_read_check(audio_tdm_pkg::PATH_CFG_ADDR, 32'h0000_0002, 1'b0);
    apb_read_check(audio_tdm_pkg::SPLIT_CFG_ADDR, 32'h0000_0000, 1'b0);
    apb_read_check(audio_tdm_pkg::FRAMING_CFG_ADDR, 32'h0000_0002, 1'b0);
    apb_read_check(12'h000, 32'h0000_0000, 1'b1);
    apb_write(audio_tdm_pkg::PATH_CFG_ADDR, 32'hFFFF_FFFF);
    apb_read_check(audio_tdm_pkg::PATH_CFG_ADDR, 32'h0000_0006, 1'b0);
    apb_write(audio_tdm_pkg::FRAMING_CFG_ADDR, 32'hFFFF_FFFF);
    apb_read_check(audio_tdm_pkg::FRAMING_CFG_ADDR, 32'h0000_000F, 1'b0);
  endtask : test_registers

  task automatic test_source_off();
    lane_level = 4'h1;
    apb_write(audio_tdm_pkg::PATH_CFG_ADDR, 32'h0000_0000);
    repeat (136) @(negedge audio_bclk);
    grab(1'b0, 1'b1, 4'h0);
    check(got_d, 64'h0, "line with source off");
    check(got_f, 64'h0, "sync with source off");
    apb_write(audio_tdm_pkg::PATH_CFG_ADDR, 32'h0000_0002);
    repeat (8) @(negedge audio_bclk);
    grab(1'b0, 1'b1, 4'h0);
    check(got_d, 64'hFFFF_FFFF_FFFF_FFFF, "line without merge");
    check(got_f, 64'h0, "sync without merge");
  endtask : test_source_off

  task automatic test_tx();
    apb_write(audio_tdm_pkg::PATH_CFG_ADDR, 32'h0000_0006);
    for (int c = 0; c < 16; c++)
    begin
      lane_level = c[0] ? 4'h6 : 4'h3;
      apb_write(audio_tdm_pkg::FRAMING_CFG_ADDR, {28'h000_0000, c[3:0]});
      repeat (192) @(negedge audio_bclk);
      grab(1'b1, c[3], 4'h0);
      check(got_d, exp_tdm(lane_level, c[2]), "tdm data");
      check(got_f, ~(~64'h0 >> (c[1] ? 1 : (c[0] ? 16 : 32))), "sync");
      check(got_k, 64'h3333_3333_3333_3333, "lane clock");
      check(got_w, 64'h0000_0000_FFFF_FFFF, "word select");
    end
  endtask : test_tx

  // Loop-back runs the device's own TDM into its splitter; otherwise the far end drives
  task automatic test_rx();
    lane_level = 4'h3;
    apb_write(audio_tdm_pkg::SPLIT_CFG_ADDR, 32'h0000_0080);
    for (int c = 0; c < 8; c++)
    begin
      loop_back = ~c[2];
      gen_pol = c[1];
      gen_delay = c[0];
      apb_write(audio_tdm_pkg::FRAMING_CFG_ADDR, {28'h000_0000, c[1:0], 2'b00});
      repeat (256) @(negedge audio_bclk);
      grab(1'b0, 1'b0, c[2] ? 4'hD : 4'h3);
      check(got_l, 64'h0, "split lanes");
    end
    apb_read_check(audio_tdm_pkg::STATUS_ADDR, 32'h0000_0001, 1'b0);
    apb_write(audio_tdm_pkg::SPLIT_CFG_ADDR, 32'h0000_0000);
    repeat (16) @(negedge audio_bclk);
    grab(1'b0, 1'b0, 4'h0);
    check(got_l, 64'h0, "lanes with split off");
    apb_read_check(audio_tdm_pkg::STATUS_ADDR, 32'h0000_0000, 1'b0);
  endtask : test_rx

  initial
  begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    lane_level = 4'h3;
    loop_back = 1'b0;
    gen_pol = 1'b0;
    gen_delay = 1'b0;
    gen_word = 64'hFFFF_0000_FFFF_FFFF;
    mismatches = 0;
    comparisons = 0;
    cycles = 0;
    // Two mclk cycles, stretched so the bclk side also sees three edges in reset
    repeat (2) @(posedge mclk);
    repeat (3) @(posedge audio_bclk);
    @(posedge mclk);
    arst_n <= 1'b1;
    test_registers();
    test_source_off();
    test_tx();
    test_rx();
    tally_and_finish();
  end
endmodule : audio_tdm_conversion_cfg_tb_top
